// *** hdl/fcl_ctrl.v ***
// Full closed loop feedback handling: overrun, delay comp, offset, blend
`timescale 1ns/10ps
`include "fcl_map.vh"

// Operation
// R1: Compare scale and motor position; beyond width raise alarm 43, stop.
// R2: Width setting of minus one skips overrun detection completely.
// R3: Width setting of zero uses a two millimetre detection width.
// R4: Linear or direct-drive systems leave the width setting at zero.
// R5: Selector 00 off, 01 type 1, 10 type 2, 11 prohibited.
// R6: Type 2 reduces lead compensation only once position droop is zero.
// R7: Speed loop PI weakened in proportion to gain, range 0 to 32767.
// R8: Pull-up direction follows torque offset sign; zero offset, no pull-up.
// R9: Torque offset is signed, -100 to 100 percent of stall current.
// R10: Dual feedback blends motor and scale positions through first-order filter.
// R11: Servo spec bit 1 enables dual feedback when set.
// R12: Software cycles power before a dual feedback enable change applies.
// R13: Filter time constant 0 to 9999 ms; zero acts as 1 ms.
// R14: Dual feedback deadband 0 to 9999 micrometres, normally zero.
// R15: Difference and filter use the same samples, once per servo cycle.
module fcl_ctrl #(
    parameter W = 32,
    parameter NW = 24,
    parameter TICKS_PER_MS = 1
) (
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire servo_tick,
    input wire signed [W-1:0] motor_pos,
    input wire signed [W-1:0] scale_pos,
    input wire signed [W-1:0] position_droop,
    input wire cmd_moving,
    output reg signed [W-1:0] fb_position,
    output reg overrun_alarm,
    output reg [7:0] alarm_code,
    output reg axis_stop,
    output reg [14:0] lead_reduce_gain,
    output reg [14:0] pi_weaken_gain,
    output reg signed [7:0] torque_offset,
    output reg pull_up_en,
    output reg pull_up_dir
);

localparam [NW-1:0] TPM = TICKS_PER_MS;
localparam [W-1:0] UM_PER_MM = `FCL_UM_PER_MM;

// Blend sequence states, one-hot
localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_FILT = 3'b010;
localparam [2:0] S_OUT = 3'b100;

// Software settings
reg [15:0] overrun_width;
reg [14:0] delay_comp_gain;
reg [1:0] servo_function_one;
reg [31:0] servo_spec_one;
reg [13:0] dual_fb_time_const;
reg [13:0] dual_fb_deadband;
reg dual_fb_active;

// Servo cycle samples and state
reg signed [W-1:0] motor_s;
reg signed [W-1:0] scale_s;
reg signed [W-1:0] fb_diff;
reg droop_zeroed;
reg [2:0] state;
reg [2:0] next_state;
reg lpf_start;
reg lpf_clear;

wire signed [W-1:0] lpf_y;
wire lpf_busy;
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i;

// Byte-lane merge; decode shared by every register write
function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
    end
endfunction

// Absolute value of a signed word, as unsigned
function [W-1:0] mag;
    input [W-1:0] v;
    begin
        mag = v[W-1] ? -v : v;
    end
endfunction

// Clamp a signed setting to 0..max (negative writes become zero)
function [13:0] clamp14;
    input [31:0] v;
    input [13:0] vmax;
    begin
        if (v[31]) begin
            clamp14 = 14'h0000;
        end else if (v > {18'h00000, vmax}) begin
            clamp14 = vmax;
        end else begin
            clamp14 = v[13:0];
        end
    end
endfunction

wire [31:0] wd_ovr = merge({{16{overrun_width[15]}}, overrun_width},
    wb_dat_i, wb_sel_i);
wire [31:0] wd_gain = merge({17'h00000, delay_comp_gain}, wb_dat_i,
    wb_sel_i);
wire [31:0] wd_tq = merge({{24{torque_offset[7]}}, torque_offset},
    wb_dat_i, wb_sel_i);
wire [31:0] wd_sf1 = merge({30'h00000000, servo_function_one}, wb_dat_i,
    wb_sel_i);
wire [31:0] wd_tc = merge({18'h00000, dual_fb_time_const}, wb_dat_i,
    wb_sel_i);
wire [31:0] wd_db = merge({18'h00000, dual_fb_deadband}, wb_dat_i,
    wb_sel_i);
wire [31:0] wd_ctl = merge(32'h00000000, wb_dat_i, wb_sel_i);
wire ctl_wr = wb_wr && wb_adr_i == `FCL_A_CTRL;
wire apply_spec = ctl_wr && wd_ctl[`FCL_CT_APPLY];
wire clear_alarm = ctl_wr && wd_ctl[`FCL_CT_CLR];

// Effective overrun width in micrometres
wire ovr_skip = overrun_width == `FCL_OVR_SKIP; // R2
wire [15:0] ovr_mm = (overrun_width == 16'h0000) ?
    `FCL_OVR_DEF_MM : overrun_width; // R3
wire [W-1:0] ovr_um = {{(W-16){1'b0}}, ovr_mm} * UM_PER_MM;

// Deadband on the motor-to-scale difference
wire [W-1:0] db_um = {{(W-14){1'b0}}, dual_fb_deadband};
wire signed [W-1:0] diff_db = (mag(fb_diff) <= db_um) ? {W{1'b0}} :
    (fb_diff[W-1] ? fb_diff + db_um : fb_diff - db_um); // R14

// Filter length in servo cycles; zero time constant taken as 1 ms
wire [13:0] tc_ms = (dual_fb_time_const == 14'h0000) ?
    `FCL_TC_MIN_MS : dual_fb_time_const; // R13
wire [NW+13:0] tc_prod = tc_ms * TPM;
wire [NW-1:0] tc_n = tc_prod[NW-1:0];

////////////////////////////////////////////////////////////////////////
// Wishbone slave: one ack per request, one cycle after it, data from a register
always @(posedge clk) begin
    if (rst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= wb_req;
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `FCL_A_OVR_W: wb_dat_o <= {{16{overrun_width[15]}},
                    overrun_width};
                `FCL_A_DC_GAIN: wb_dat_o <= {17'h00000, delay_comp_gain};
                `FCL_A_TQ_OFS: wb_dat_o <= {{24{torque_offset[7]}},
                    torque_offset};
                `FCL_A_SFUNC1: wb_dat_o <= {30'h00000000,
                    servo_function_one};
                `FCL_A_SSPEC1: wb_dat_o <= servo_spec_one;
                `FCL_A_DFB_TC: wb_dat_o <= {18'h00000, dual_fb_time_const};
                `FCL_A_DFB_DB: wb_dat_o <= {18'h00000, dual_fb_deadband};
                `FCL_A_STATUS: wb_dat_o <= {25'h0000000, pull_up_en,
                    pull_up_dir, droop_zeroed,
                    servo_function_one == `FCL_DC_BAD, dual_fb_active,
                    axis_stop, overrun_alarm};
                `FCL_A_FB_DIFF: wb_dat_o <= fb_diff;
                `FCL_A_FB_POS: wb_dat_o <= fb_position;
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Setting registers; out-of-range width, offset, time constant and deadband values are clamped on write
always @(posedge clk) begin
    if (rst) begin
        overrun_width <= `FCL_RST_OVR_W;
        delay_comp_gain <= `FCL_RST_GAIN;
        torque_offset <= `FCL_RST_TQ;
        servo_function_one <= `FCL_DC_OFF;
        servo_spec_one <= 32'h00000000;
        dual_fb_time_const <= `FCL_RST_TC;
        dual_fb_deadband <= `FCL_RST_DB;
    end else if (wb_wr) begin
        case (wb_adr_i)
            `FCL_A_OVR_W: begin
                // Below -1 is taken as -1, above 32767 as 32767
                if (wd_ovr[31] && wd_ovr[15:0] != `FCL_OVR_SKIP) begin
                    overrun_width <= `FCL_OVR_SKIP;
                end else if (!wd_ovr[31] && wd_ovr[30:15] != 16'h0000) begin
                    overrun_width <= `FCL_OVR_MAX;
                end else begin
                    overrun_width <= wd_ovr[15:0];
                end
            end
            `FCL_A_DC_GAIN: delay_comp_gain <= wd_gain[14:0]; // R7
            `FCL_A_TQ_OFS: begin
                if ($signed(wd_tq) > $signed({24'h000000, `FCL_TQ_MAX})) begin
                    torque_offset <= `FCL_TQ_MAX; // R9
                end else if ($signed(wd_tq) <
                    $signed({24'hFFFFFF, `FCL_TQ_MIN})) begin
                    torque_offset <= `FCL_TQ_MIN; // R9
                end else begin
                    torque_offset <= wd_tq[7:0];
                end
            end
            `FCL_A_SFUNC1: servo_function_one <= wd_sf1[1:0];
            `FCL_A_SSPEC1: servo_spec_one <= merge(servo_spec_one,
                wb_dat_i, wb_sel_i);
            `FCL_A_DFB_TC: dual_fb_time_const <= clamp14(wd_tc,
                `FCL_TC_MAX); // R13
            `FCL_A_DFB_DB: dual_fb_deadband <= clamp14(wd_db,
                `FCL_DB_MAX); // R14
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Enable bit only takes hold on the power-cycle stand-in (apply)
always @(posedge clk) begin
    if (rst) begin
        dual_fb_active <= 1'b0;
    end else if (apply_spec) begin
        dual_fb_active <= servo_spec_one[`FCL_SP1_DFB]; // R11 R12
    end
end

////////////////////////////////////////////////////////////////////////
// Overrun: one sample pair per servo cycle; set wins over clear
always @(posedge clk) begin
    if (rst) begin
        motor_s <= {W{1'b0}};
        scale_s <= {W{1'b0}};
        fb_diff <= {W{1'b0}};
        overrun_alarm <= 1'b0;
        axis_stop <= 1'b0;
        alarm_code <= `FCL_ALARM_NONE;
    end else begin
        if (servo_tick && state == S_IDLE) begin
            motor_s <= motor_pos; // R15
            scale_s <= scale_pos; // R15
            fb_diff <= scale_pos - motor_pos; // R1
        end
        if (!ovr_skip && mag(fb_diff) > ovr_um) begin
            overrun_alarm <= 1'b1; // R1
            axis_stop <= 1'b1; // R1
            alarm_code <= `FCL_ALARM_OVERRUN; // R1
        end else if (clear_alarm) begin
            overrun_alarm <= 1'b0;
            axis_stop <= 1'b0;
            alarm_code <= `FCL_ALARM_NONE;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Blend sequence: sample, filter the difference, publish feedback
always @* begin
    next_state = state;
    case (state)
        S_IDLE: if (servo_tick) next_state = S_FILT;
        S_FILT: if (!lpf_busy && !lpf_start) next_state = S_OUT;
        S_OUT: next_state = S_IDLE;
        default: next_state = S_IDLE;
    endcase
end

always @(posedge clk) begin
    if (rst) begin
        state <= S_IDLE;
        lpf_start <= 1'b0;
        lpf_clear <= 1'b1;
        fb_position <= {W{1'b0}};
    end else begin
        state <= next_state;
        lpf_start <= state == S_IDLE && servo_tick && dual_fb_active;
        lpf_clear <= !dual_fb_active;
        if (state == S_OUT) begin
            // Fast motion rides on motor, slow settles onto scale
            fb_position <= dual_fb_active ? motor_s + lpf_y : scale_s; // R10
        end
    end
end

fcl_lpf #(
    .W(W),
    .NW(NW)
) u_lpf (
    .clk(clk),
    .rst(rst),
    .clear(lpf_clear),
    .start(lpf_start),
    .x(diff_db),
    .n(tc_n),
    .y(lpf_y),
    .busy(lpf_busy)
);

////////////////////////////////////////////////////////////////////////
// Delay compensation and torque offset outputs
always @(posedge clk) begin
    if (rst) begin
        droop_zeroed <= 1'b0;
        lead_reduce_gain <= 15'h0000;
        pi_weaken_gain <= 15'h0000;
        pull_up_en <= 1'b0;
        pull_up_dir <= 1'b0;
    end else begin
        // Held from droop reaching zero until motion is commanded again
        if (position_droop == {W{1'b0}}) begin
            droop_zeroed <= 1'b1; // R6
        end else if (cmd_moving) begin
            droop_zeroed <= 1'b0;
        end
        case (servo_function_one) // R5
            `FCL_DC_TYPE1: begin
                pi_weaken_gain <= delay_comp_gain; // R7
                lead_reduce_gain <= delay_comp_gain;
            end
            `FCL_DC_TYPE2: begin
                pi_weaken_gain <= delay_comp_gain; // R7
                lead_reduce_gain <= droop_zeroed ?
                    delay_comp_gain : 15'h0000; // R6
            end
            // Prohibited code acts as disabled, flagged in status
            default: begin
                pi_weaken_gain <= 15'h0000;
                lead_reduce_gain <= 15'h0000;
            end
        endcase
        pull_up_en <= torque_offset != `FCL_RST_TQ; // R8
        pull_up_dir <= ~torque_offset[7]; // R8
    end
end

endmodule

// *** hdl/fcl_lpf.v ***
// First-order delay filter stepped once per servo cycle by serial division
`timescale 1ns/10ps
module fcl_lpf #(
    parameter W = 32,
    parameter NW = 24
) (
    input wire clk,
    input wire rst,
    input wire clear,
    input wire start,
    input wire signed [W-1:0] x,
    input wire [NW-1:0] n,
    output reg signed [W-1:0] y,
    output reg busy
);

localparam CW = 6;
localparam [CW-1:0] STEPS = W + 1;

reg [W:0] num;
reg [W:0] quo;
reg [W:0] rem;
reg neg;
reg [CW-1:0] cnt;
wire signed [W:0] err = {x[W-1], x} - {y[W-1], y};
wire [W+1:0] trial = {rem, num[W]} - {{(W+2-NW){1'b0}}, n};

////////////////////////////////////////////////////////////////////////
// Restoring division of the error by n, then one filter step.
// Serial to keep area small; starts at least W+3 clocks apart, so ticks at least W+6.
always @(posedge clk) begin
    if (rst || clear) begin
        y <= {W{1'b0}};
        busy <= 1'b0;
        num <= {(W+1){1'b0}};
        quo <= {(W+1){1'b0}};
        rem <= {(W+1){1'b0}};
        neg <= 1'b0;
        cnt <= {CW{1'b0}};
    end else if (!busy) begin
        if (start) begin
            neg <= err[W];
            num <= err[W] ? -err : err;
            quo <= {(W+1){1'b0}};
            rem <= {(W+1){1'b0}};
            cnt <= STEPS;
            busy <= 1'b1;
        end
    end else if (cnt != {CW{1'b0}}) begin
        num <= {num[W-1:0], 1'b0};
        if (!trial[W+1]) begin
            rem <= trial[W:0];
            quo <= {quo[W-1:0], 1'b1};
        end else begin
            rem <= {rem[W-1:0], num[W]};
            quo <= {quo[W-1:0], 1'b0};
        end
        cnt <= cnt - 1'b1;
    end else begin
        // Step toward the input by error divided by the time count
        y <= neg ? y - quo[W-1:0] : y + quo[W-1:0];
        busy <= 1'b0;
    end
end

endmodule

// *** pkg/fcl_map.vh ***
// Register map, field positions, reset values and constants of the block
`ifndef FCL_MAP_VH
`define FCL_MAP_VH
// Register byte offsets on the Wishbone slave
`define FCL_A_OVR_W 8'h00
`define FCL_A_DC_GAIN 8'h04
`define FCL_A_TQ_OFS 8'h08
`define FCL_A_SFUNC1 8'h0C
`define FCL_A_SSPEC1 8'h10
`define FCL_A_DFB_TC 8'h14
`define FCL_A_DFB_DB 8'h18
`define FCL_A_STATUS 8'h1C
`define FCL_A_CTRL 8'h20
`define FCL_A_FB_DIFF 8'h24
`define FCL_A_FB_POS 8'h28
// Field positions
`define FCL_SF1_DC_HI 1
`define FCL_SF1_DC_LO 0
`define FCL_SP1_DFB 1
`define FCL_CT_APPLY 0
`define FCL_CT_CLR 1
`define FCL_ST_ALARM 0
`define FCL_ST_STOP 1
`define FCL_ST_DFB 2
`define FCL_ST_BADSEL 3
`define FCL_ST_DROOP0 4
`define FCL_ST_PULLDIR 5
`define FCL_ST_PULLEN 6
// Delay compensation changeover selector codes
`define FCL_DC_OFF 2'h0
`define FCL_DC_TYPE1 2'h1
`define FCL_DC_TYPE2 2'h2
`define FCL_DC_BAD 2'h3
// Reset values
`define FCL_RST_OVR_W 16'h0000
`define FCL_RST_GAIN 15'h0000
`define FCL_RST_TQ 8'h00
`define FCL_RST_TC 14'h0000
`define FCL_RST_DB 14'h0000
// Setting limits and special values
`define FCL_OVR_SKIP 16'hFFFF
`define FCL_OVR_MAX 16'h7FFF
`define FCL_OVR_DEF_MM 16'h0002
`define FCL_UM_PER_MM 16'h03E8
`define FCL_TQ_MAX 8'h64
`define FCL_TQ_MIN 8'h9C
`define FCL_TC_MAX 14'h270F
`define FCL_DB_MAX 14'h270F
`define FCL_TC_MIN_MS 14'h0001
// Alarm number raised on overrun
`define FCL_ALARM_OVERRUN 8'h2B
`define FCL_ALARM_NONE 8'h00
`endif

// *** verification/fcl_ctrl_assertions.sv ***
// Port-level concurrent checks for the feedback controller
`timescale 1ns/10ps
module fcl_ctrl_assertions #(
    parameter W = 32
) (
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire servo_tick,
    input wire signed [W-1:0] fb_position,
    input wire overrun_alarm,
    input wire [7:0] alarm_code,
    input wire axis_stop,
    input wire signed [7:0] torque_offset,
    input wire pull_up_en,
    input wire pull_up_dir
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire clr_req;
    reg [7:0] since_tick;
    ////////////////////////////////////////////////////////////////////////
    // Alarm clear write as seen on the bus
    assign clr_req = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h20
        && wb_dat_i[1];
    // Cycles since the last servo tick, saturating
    always @(posedge clk) begin
        if (rst || servo_tick)
            since_tick <= 8'h00;
        else if (since_tick != 8'hFF)
            since_tick <= since_tick + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_alarm_code: assert property (
        alarm_code == (overrun_alarm ? 8'h2B : 8'h00))
        else $error("alarm code does not follow alarm");
    a_stop_alarm: assert property (axis_stop == overrun_alarm)
        else $error("axis stop differs from alarm");
    a_alarm_clear: assert property (
        $fell(overrun_alarm) |-> $past(clr_req) || $past(clr_req, 2))
        else $error("alarm dropped without clear");
    a_pull_up: assert property (
        $stable(torque_offset) [*3] |-> pull_up_en == (torque_offset != 8'h00)
        && pull_up_dir == !torque_offset[7])
        else $error("pull-up does not follow offset");
    a_tq_range: assert property (
        $signed(torque_offset) >= $signed(8'h9C)
        && $signed(torque_offset) <= $signed(8'h64))
        else $error("torque offset out of range");
    a_fb_quiet: assert property (
        !$stable(fb_position) |-> since_tick < 8'h2D)
        else $error("feedback moved outside a servo cycle");
    c_alarm: cover property ($rose(overrun_alarm));
    c_pull: cover property ($rose(pull_up_en));
    c_fb: cover property (!$stable(fb_position));
endmodule
bind fcl_ctrl fcl_ctrl_assertions #(.W(W)) u_fcl_chk (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .servo_tick(servo_tick),
    .fb_position(fb_position), .overrun_alarm(overrun_alarm),
    .alarm_code(alarm_code), .axis_stop(axis_stop),
    .torque_offset(torque_offset), .pull_up_en(pull_up_en),
    .pull_up_dir(pull_up_dir)
);

// *** verification/fcl_ctrl_tb_top.sv ***
// Self-checking bench for the feedback controller
`timescale 1ns/10ps
`include "fcl_map.vh"
module fcl_ctrl_tb_top;
    reg clk;
    reg rst;
    reg wb_cyc_i;
    reg wb_stb_i;
    reg wb_we_i;
    reg [7:0] wb_adr_i;
    reg [31:0] wb_dat_i;
    reg cmd_moving;
    reg signed [31:0] position_droop;
    reg signed [31:0] base;
    reg signed [31:0] gap;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire servo_tick;
    wire signed [31:0] motor_pos;
    wire signed [31:0] scale_pos;
    wire signed [31:0] fb_position;
    wire overrun_alarm;
    wire [7:0] alarm_code;
    wire axis_stop;
    wire [14:0] lead_reduce_gain;
    wire [14:0] pi_weaken_gain;
    wire signed [7:0] torque_offset;
    wire pull_up_en;
    wire pull_up_dir;
    integer n_fail;
    integer num_checks;
    integer i;
    reg [31:0] seed;
    reg [31:0] q;
    reg signed [31:0] y;
    fcl_ctrl u_fcl_ctrl (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .servo_tick(servo_tick),
        .motor_pos(motor_pos), .scale_pos(scale_pos),
        .position_droop(position_droop), .cmd_moving(cmd_moving),
        .fb_position(fb_position), .overrun_alarm(overrun_alarm),
        .alarm_code(alarm_code), .axis_stop(axis_stop),
        .lead_reduce_gain(lead_reduce_gain),
        .pi_weaken_gain(pi_weaken_gain), .torque_offset(torque_offset),
        .pull_up_en(pull_up_en), .pull_up_dir(pull_up_dir));
    fcl_fb_model u_fcl_fb_model (.clk(clk), .rst(rst), .base(base),
        .gap(gap), .servo_tick(servo_tick), .motor_pos(motor_pos),
        .scale_pos(scale_pos));
    ////////////////////////////////////////////////////////////////////////
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // Offset as the controller must hold it after clamping
    function signed [7:0] f_tq(input signed [31:0] v);
        begin
            if (v > 100)
                f_tq = 8'h64;
            else if (v < -100)
                f_tq = 8'h9C;
            else
                f_tq = v[7:0];
        end
    endfunction
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("Error %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Classic single cycle; waits for ack, bench timeout ends a hang
    task wb(input [7:0] a, input [31:0] d, input w);
        begin
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            @(posedge clk);
            while (wb_ack_o !== 1'b1)
                @(posedge clk);
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Past n ticks, once the new feedback has settled
    task tk(input integer n);
        begin
            repeat (n) @(posedge servo_tick);
            repeat (44) @(posedge clk);
        end
    endtask
    task ovr(input [31:0] w, input signed [31:0] g, input e);
        begin
            gap <= 0;
            tk(2);
            wb(`FCL_A_OVR_W, w, 1'b1);
            wb(`FCL_A_CTRL, 32'h2, 1'b1);
            chk("alm_clr", 0, overrun_alarm);
            gap <= g;
            tk(2);
            chk("alarm", e, overrun_alarm);
            chk("code", {8{e}} & `FCL_ALARM_OVERRUN, alarm_code);
            chk("fb_scale", scale_pos, fb_position);
        end
    endtask
    task tq(input signed [31:0] v);
        reg signed [7:0] e;
        begin
            e = f_tq(v);
            wb(`FCL_A_TQ_OFS, v, 1'b1);
            repeat (3) @(posedge clk);
            chk("tq", e, torque_offset);
            chk("pull_en", e != 0, pull_up_en);
            chk("pull_dir", !e[7], pull_up_dir);
        end
    endtask
    task dc(input [1:0] s, input [14:0] g);
        begin
            wb(`FCL_A_DC_GAIN, {17'h0, g}, 1'b1);
            wb(`FCL_A_SFUNC1, {30'h0, s}, 1'b1);
            repeat (3) @(posedge clk);
            chk("lead", s == 2'h1 ? g : 15'h0, lead_reduce_gain);
            chk("pi", s[0] ^ s[1] ? g : 15'h0, pi_weaken_gain);
            wb(`FCL_A_STATUS, 0, 1'b0);
            chk("badsel", s == 2'h3, q[`FCL_ST_BADSEL]);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run needs well under this many cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_fail = n_fail + 1;
        results;
    end
    initial begin
        n_fail = 0;
        num_checks = 0;
        seed = 32'd54;
        rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        cmd_moving = 1'b1;
        position_droop = 5;
        base = 0;
        gap = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset map, last word unmapped; status shows positive pull side
        for (i = 0; i < 12; i = i + 1) begin
            wb(8'(i * 4), 0, 1'b0);
            chk("reset_rd", i == 7 ? 32'h20 : 0, q);
        end
        wb(8'h30, 32'hFFFFFFFF, 1'b1);
        wb(8'h30, 0, 1'b0);
        chk("unmapped", 0, q);
        // Blend with tc 0, then deadband, then a 5 ms filter
        seed = xs(seed);
        base <= $signed(seed % 32'd1000);
        wb(`FCL_A_SSPEC1, 32'h2, 1'b1);
        wb(`FCL_A_CTRL, 32'h1, 1'b1);
        wb(`FCL_A_STATUS, 0, 1'b0);
        chk("dfb_on", 1, q[`FCL_ST_DFB]);
        gap <= 500;
        tk(2);
        chk("fb_tc0", scale_pos, fb_position);
        wb(`FCL_A_DFB_DB, 600, 1'b1);
        tk(2);
        chk("fb_band", motor_pos, fb_position);
        // Time constant first, under the band, so no filter step is missed
        wb(`FCL_A_DFB_TC, 5, 1'b1);
        tk(1);
        wb(`FCL_A_DFB_DB, 0, 1'b1);
        y = 0;
        for (i = 0; i < 3; i = i + 1) begin
            tk(1);
            y = y + (500 - y) / 5;
            chk("fb_filt", motor_pos + y, fb_position);
        end
        wb(`FCL_A_SSPEC1, 0, 1'b1);
        wb(`FCL_A_CTRL, 32'h1, 1'b1);
        // Overrun widths at their edges, both directions
        ovr(32'h1, 1000, 1'b0);
        ovr(32'h1, 1001, 1'b1);
        ovr(32'h0, 2000, 1'b0);
        ovr(32'h0, -2001, 1'b1);
        ovr(32'hFFFFFFFF, 50000000, 1'b0);
        ovr(32'h7FFF, 32767001, 1'b1);
        // Torque offset: limits, clamping, zero, random
        tq(100);
        tq(-100);
        tq(120);
        tq(-120);
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            tq($signed(seed % 32'd201) - 100);
        end
        tq(0);
        // Every selector code, then type 2 hold on zero droop
        seed = xs(seed);
        for (i = 0; i < 4; i = i + 1)
            dc(i[1:0], seed[14:0]);
        dc(2'h1, 15'h7FFF);
        dc(2'h2, 15'h7FFF);
        position_droop <= 0;
        cmd_moving <= 1'b0;
        repeat (3) @(posedge clk);
        chk("lead_t2", 15'h7FFF, lead_reduce_gain);
        position_droop <= 5;
        repeat (3) @(posedge clk);
        chk("lead_hld", 15'h7FFF, lead_reduce_gain);
        cmd_moving <= 1'b1;
        repeat (3) @(posedge clk);
        chk("lead_mov", 0, lead_reduce_gain);
        results;
    end
endmodule

// *** verification/fcl_fb_model.sv ***
// Motor encoder and linear scale seen by the controller
`timescale 1ns/10ps
module fcl_fb_model #(
    parameter W = 32,
    parameter PERIOD = 48
) (
    input wire clk,
    input wire rst,
    input wire signed [W-1:0] base,
    input wire signed [W-1:0] gap,
    output reg servo_tick,
    output reg signed [W-1:0] motor_pos,
    output reg signed [W-1:0] scale_pos
);
    reg [7:0] cnt;
    // Ticks spaced above the minimum; positions move together mid-period
    always @(posedge clk) begin
        if (rst) begin
            cnt <= 8'h00;
            servo_tick <= 1'b0;
        end else begin
            cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
            servo_tick <= (cnt == 8'(PERIOD - 1));
        end
        if (rst || cnt == 8'(PERIOD / 2)) begin
            motor_pos <= base;
            scale_pos <= base + gap;
        end
    end
endmodule
